// File: sep_assertions.sv
// Checker of the two-wire link between host end and device end
`timescale 1ns/10ps
`default_nettype none
module sep_assertions import sep_pkg::*; (
   input wire logic clk_i,        // System clock
   input wire logic rst_b_i,      // Async reset, active low
   input wire logic scl_host_o,   // Host clock value
   input wire logic scl_host_oe,  // Host clock pull
   input wire logic sda_host_o,   // Host data value
   input wire logic sda_host_oe,  // Host data pull
   input wire logic sda_dev_o,    // Device data value
   input wire logic sda_dev_oe,   // Device data pull
   input wire logic scl,          // Resolved clock
   input wire logic sda           // Resolved data
);
   logic scl_ff, sda_ff, first_ff, rd_ff;
   logic [3:0] bitn_ff;
   logic [7:0] sh_ff;
   logic start, stop, ninth;

   // ****************************************
   // Line event decoding
   // ****************************************
   assign start = scl && scl_ff && sda_ff && !sda;
   assign stop = scl && scl_ff && !sda_ff && sda;
   assign ninth = scl && !scl_ff && (bitn_ff == SEP_ACK_BIT);

   // Previous line levels
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_ff <= 1'h1;
         sda_ff <= 1'h1;
      end else begin
         scl_ff <= scl;
         sda_ff <= sda;
      end
   end

   // Bit position, first byte and read direction since start
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bitn_ff <= 4'h0;
         first_ff <= 1'h0;
         rd_ff <= 1'h0;
         sh_ff <= 8'h00;
      end else if (start) begin
         bitn_ff <= 4'h0;
         first_ff <= 1'h1;
         rd_ff <= 1'h0;
      end else if (ninth) begin
         bitn_ff <= 4'h0;
         first_ff <= 1'h0;
         rd_ff <= first_ff ? sh_ff[0] : rd_ff;
      end else if (scl && !scl_ff) begin
         bitn_ff <= bitn_ff + 4'h1;
         sh_ff <= {sh_ff[6:0], sda};
      end
   end

   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_addr_ack;
      ninth && first_ff && !sda;
   endsequence
   sequence s_nack;
      ninth && rd_ff && !first_ff && sda;
   endsequence

   a_dev_drain: assert property (sda_dev_oe |-> !sda_dev_o)
      else $error("device drives data high");
   a_host_drain: assert property ((sda_host_oe |-> !sda_host_o) and
      (scl_host_oe |-> !scl_host_o))
      else $error("host drives a line high");
   // Hand-over overlap at a byte edge is harmless while the clock is low
   a_single_driver: assert property (!(sda_dev_oe && sda_host_oe && scl))
      else $error("both ends drive data while clock high");
   a_drive_scl_low: assert property ($rose(sda_dev_oe) |-> !scl)
      else $error("device data change while clock high");
   a_ack_dev_type: assert property (s_addr_ack |-> sh_ff[7:4] == SEP_DEV_TYPE)
      else $error("address acknowledged with wrong device type");
   a_host_addr_release: assert property (ninth && first_ff |-> !sda_host_oe)
      else $error("host holds data in address ack slot");
   a_dev_read_release: assert property (ninth && rd_ff && !first_ff |-> !sda_dev_oe)
      else $error("device holds data in master ack slot");
   a_data_only_read: assert property ($rose(sda_dev_oe) &&
      bitn_ff != SEP_ACK_BIT |-> rd_ff)
      else $error("device sends data outside a read");
   a_nack_release: assert property (s_nack |=> !sda_dev_oe throughout (##[0:200] stop))
      else $error("device drives after master nack");
   a_stop_quiet: assert property (stop |-> ##4 (!sda_dev_oe) [*8])
      else $error("device drives after stop");
endmodule
`default_nettype wire

// File: sep_dev_end.sv
// Device end: serial EEPROM slave read path
// How it works
// - Read starts with start, address, bit one
// - Counter holds last accessed location plus one
// - Current read: acknowledge, send byte at counter
// - Master nack and stop end single read
// - Random read begins with dummy write address
// - Repeated start, read address, acknowledge, send byte
// - Each master acknowledge brings another byte
// - Nack or stop ends sequential read
// - Reads increment all counter bits
// - Counter wraps, data keeps flowing
// - Word address is one byte, 256 locations
// - Answer only device type 1010 address
// - Release after byte, ack low ninth clock
`timescale 1ns/10ps
`default_nettype none
module sep_dev_end import sep_pkg::*; (
   input wire logic clk_i,            // System clock, 10 MHz
   input wire logic rst_b_i,          // Async reset, active low
   input wire logic ce_i,             // Clock enable, freezes all state
   sep_if.dev bus,                    // Two-wire link
   input wire logic [2:0] sel_i,      // Low slave address bits
   input wire logic ld_we_i,          // Array preload strobe
   input wire logic [7:0] ld_addr_i,  // Array preload address
   input wire logic [7:0] ld_data_i,  // Array preload data
   output logic [7:0] addr_cnt_o,     // Address counter
   output logic active_o              // Transaction in progress
);
   // ****************************************
   // Declarations
   // ****************************************
   sep_dst_e st_ff;
   logic [3:0] bit_ff;
   logic [7:0] sh_ff;
   logic [7:0] addr_ff;
   logic rw_ff;
   logic ack_ff;
   logic drv_ff;
   logic [7:0] mem_ff [SEP_DEPTH];
   logic scl_s;
   logic scl_r;
   logic scl_f;
   logic sda_s;
   logic sda_r;
   logic sda_f;
   logic start_ev;
   logic stop_ev;
   logic bit8;
   logic adr_match;
   logic load_byte;
   logic rx_st;
   logic [7:0] rd_byte;

   // ****************************************
   // Line synchronisers
   // ****************************************
   sep_sync u_scl (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .d_i(bus.scl),
      .q_o(scl_s),
      .rise_o(scl_r),
      .fall_o(scl_f)
   );

   sep_sync u_sda (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .d_i(bus.sda),
      .q_o(sda_s),
      .rise_o(sda_r),
      .fall_o(sda_f)
   );

   // ****************************************
   // Bus events and decode
   // ****************************************
   // Data edges while clock high are start and stop
   assign start_ev = scl_s && sda_f;
   assign stop_ev = scl_s && sda_r;
   assign bit8 = (bit_ff == SEP_ACK_BIT);
   assign rx_st = (st_ff == DS_DEVADR) || (st_ff == DS_WORD);
   // Device type and select bits must both match
   assign adr_match = (sh_ff[7:4] == SEP_DEV_TYPE) && (sh_ff[3:1] == sel_i);
   assign rd_byte = mem_ff[addr_ff];
   // Load a byte after address ack on read, or after master ack
   assign load_byte = scl_f && (((st_ff == DS_ACKDEV) && rw_ff) ||
                                ((st_ff == DS_TXACK) && ack_ff));

   // ****************************************
   // Array storage
   // ****************************************
   // Preload port; writes over the link are not part of this path
   always_ff @(posedge clk_i) begin
      if (ce_i && ld_we_i) begin
         mem_ff[ld_addr_i] <= ld_data_i;
      end
   end

   // ****************************************
   // Transaction state
   // ****************************************
   // Start resyncs anywhere, stop returns to idle
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_ff <= DS_IDLE;
      end else if (ce_i) begin
         if (start_ev) begin
            st_ff <= DS_DEVADR;
         end else if (stop_ev) begin
            st_ff <= DS_IDLE;
         end else if (scl_f) begin
            case (st_ff)
               DS_DEVADR: begin
                  if (bit8) begin
                     st_ff <= adr_match ? DS_ACKDEV : DS_WAIT;
                  end
               end
               DS_ACKDEV: begin
                  st_ff <= rw_ff ? DS_TX : DS_WORD;
               end
               DS_WORD: begin
                  if (bit8) begin
                     st_ff <= DS_ACKWORD;
                  end
               end
               DS_ACKWORD: begin
                  st_ff <= DS_WAIT;  // Write data bytes ignored
               end
               DS_TX: begin
                  if (bit8) begin
                     st_ff <= DS_TXACK;
                  end
               end
               DS_TXACK: begin
                  st_ff <= ack_ff ? DS_TX : DS_WAIT;
               end
               default: begin
                  st_ff <= st_ff;
               end
            endcase
         end
      end
   end

   // Bit counter: steps up on clock rise while receiving, on clock fall while sending
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bit_ff <= 4'h0;
      end else if (ce_i) begin
         if (start_ev) begin
            bit_ff <= 4'h0;
         end else if (scl_r && rx_st) begin
            bit_ff <= bit_ff + 4'h1;
         end else if (load_byte) begin
            bit_ff <= 4'h1;
         end else if (scl_f && (st_ff == DS_TX) && !bit8) begin
            bit_ff <= bit_ff + 4'h1;
         end else if (scl_f && (st_ff == DS_ACKDEV)) begin
            bit_ff <= 4'h0;
         end
      end
   end

   // Shift register, MSB first both ways
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sh_ff <= 8'h00;
      end else if (ce_i) begin
         if (scl_r && rx_st) begin
            sh_ff <= {sh_ff[6:0], sda_s};
         end else if (load_byte) begin
            sh_ff <= rd_byte;
         end else if (scl_f && (st_ff == DS_TX)) begin
            sh_ff <= {sh_ff[6:0], 1'h0};
         end
      end
   end

   // Direction bit of each received device address
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rw_ff <= SEP_WR_BIT;
      end else if (ce_i && scl_f && (st_ff == DS_DEVADR) && bit8) begin
         rw_ff <= sh_ff[0];
      end
   end

   // Master acknowledge sampled on the ninth clock
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ack_ff <= 1'h0;
      end else if (ce_i && scl_r && (st_ff == DS_TXACK)) begin
         ack_ff <= !sda_s;
      end
   end

   // ****************************************
   // Address counter
   // ****************************************
   // Dummy write loads it, every byte sent steps it
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         addr_ff <= SEP_ADDR_RST;
      end else if (ce_i) begin
         if (scl_f && (st_ff == DS_WORD) && bit8) begin
            addr_ff <= sh_ff;
         end else if (load_byte) begin
            addr_ff <= addr_ff + 8'h01;
         end
      end
   end

   // ****************************************
   // Data line drive
   // ****************************************
   // Pull low for acks and zero bits, release otherwise
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         drv_ff <= 1'h0;
      end else if (ce_i) begin
         if (start_ev || stop_ev) begin
            drv_ff <= 1'h0;
         end else if (scl_f) begin
            case (st_ff)
               DS_DEVADR: begin
                  drv_ff <= bit8 && adr_match;
               end
               DS_WORD: begin
                  drv_ff <= bit8;
               end
               DS_ACKDEV, DS_TXACK: begin
                  drv_ff <= load_byte && !rd_byte[7];
               end
               DS_TX: begin
                  drv_ff <= !bit8 && !sh_ff[6];
               end
               default: begin
                  drv_ff <= 1'h0;
               end
            endcase
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign bus.sda_dev_o = 1'h0;     // Open drain: only ever pulls low
   assign bus.sda_dev_oe = drv_ff;
   assign addr_cnt_o = addr_ff;
   assign active_o = (st_ff != DS_IDLE);
endmodule
`default_nettype wire

// File: sep_host_end.sv
// Host end: two-wire master issuing EEPROM reads
`timescale 1ns/10ps
`default_nettype none
module sep_host_end import sep_pkg::*; (
   input wire logic clk_i,         // System clock, 10 MHz
   input wire logic rst_b_i,       // Async reset, active low
   input wire logic ce_i,          // Clock enable, freezes all state
   sep_if.host bus,                // Two-wire link
   input wire logic req_i,         // Read request
   input wire logic rand_i,        // Random read, else current address
   input wire logic [2:0] sel_i,   // Low slave address bits
   input wire logic [7:0] word_i,  // Word address for random read
   input wire logic [7:0] len_i,   // Bytes to read, zero means one
   output logic ready_o,           // Request may be taken
   output logic [7:0] rd_data_o,   // Received byte
   output logic rd_valid_o,        // Byte valid pulse
   output logic done_o,            // Transfer finished pulse
   output logic nack_o             // Address not acknowledged pulse
);
   sep_hst_e st_ff;
   sep_seq_e seq_ff;
   logic [7:0] q_ff;
   logic [1:0] ph_ff;
   logic [3:0] bit_ff;
   logic [7:0] sh_ff;
   logic [7:0] left_ff;
   logic [7:0] word_ff;
   logic [2:0] sel_ff;
   logic rand_ff;
   logic ack_ff;
   logic sda_low_ff;
   logic scl_low_ff;
   logic sda_s;
   logic tick;
   logic tx;
   logic take;

   sep_sync u_sda (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .d_i(bus.sda),
      .q_o(sda_s),
      .rise_o(),
      .fall_o()
   );

   assign ready_o = (st_ff == HS_IDLE);
   assign take = ce_i && req_i && ready_o;
   assign tick = ce_i && (st_ff != HS_IDLE) && (q_ff == SEP_Q_LAST);
   assign tx = (seq_ff != SQ_DATA);

   // Quarter-period divider for the serial clock
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q_ff <= 8'h00;
      end else if (ce_i) begin
         q_ff <= (tick || take) ? 8'h00 : q_ff + 8'h01;
      end
   end

   // Sequencer: start, address bytes, data bytes, stop
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_ff <= HS_IDLE;
         seq_ff <= SQ_RADR;
         ph_ff <= 2'h0;
         bit_ff <= 4'h0;
         sh_ff <= 8'h00;
         left_ff <= 8'h00;
         word_ff <= 8'h00;
         sel_ff <= 3'h0;
         rand_ff <= 1'h0;
         ack_ff <= 1'h0;
      end else if (take) begin
         st_ff <= HS_START;
         seq_ff <= rand_i ? SQ_WADR : SQ_RADR;
         ph_ff <= 2'h0;
         left_ff <= (len_i == 8'h00) ? 8'h01 : len_i;
         word_ff <= word_i;
         sel_ff <= sel_i;
         rand_ff <= rand_i;
      end else if (tick) begin
         ph_ff <= ph_ff + 2'h1;
         if (st_ff == HS_START && ph_ff == 2'h3) begin
            st_ff <= HS_BYTE;
            bit_ff <= 4'h0;
            sh_ff <= {SEP_DEV_TYPE, sel_ff,
                      (seq_ff == SQ_WADR) ? SEP_WR_BIT : SEP_RD_BIT};
         end else if (st_ff == HS_STOP && ph_ff == 2'h3) begin
            st_ff <= HS_IDLE;
         end else if (st_ff == HS_BYTE && ph_ff == 2'h2) begin
            if (bit_ff == SEP_ACK_BIT) begin
               ack_ff <= !sda_s;
            end else begin
               sh_ff <= {sh_ff[6:0], sda_s};
            end
         end else if (st_ff == HS_BYTE && ph_ff == 2'h3) begin
            bit_ff <= bit_ff + 4'h1;
            if (bit_ff == SEP_ACK_BIT) begin
               bit_ff <= 4'h0;
               if (tx && !ack_ff) begin
                  st_ff <= HS_STOP;
               end else if (seq_ff == SQ_WADR) begin
                  seq_ff <= SQ_WORD;
                  sh_ff <= word_ff;
               end else if (seq_ff == SQ_WORD) begin
                  seq_ff <= SQ_RADR;
                  st_ff <= HS_START;
               end else if (seq_ff == SQ_RADR) begin
                  seq_ff <= SQ_DATA;
               end else if (left_ff > 8'h01) begin
                  left_ff <= left_ff - 8'h01;
               end else begin
                  st_ff <= HS_STOP;
               end
            end
         end
      end
   end

   // Line drive per quarter phase
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sda_low_ff <= 1'h0;
         scl_low_ff <= 1'h0;
      end else if (tick) begin
         case (ph_ff)
            2'h0: begin
               if (st_ff == HS_START) begin
                  sda_low_ff <= 1'h0;
               end else if (st_ff == HS_STOP) begin
                  sda_low_ff <= 1'h1;
               end else if (bit_ff == SEP_ACK_BIT) begin
                  sda_low_ff <= !tx && (left_ff > 8'h01);
               end else begin
                  sda_low_ff <= tx && !sh_ff[7];
               end
            end
            2'h1: begin
               scl_low_ff <= 1'h0;
            end
            2'h2: begin
               if (st_ff == HS_START) begin
                  sda_low_ff <= 1'h1;
               end else if (st_ff == HS_STOP) begin
                  sda_low_ff <= 1'h0;
               end
            end
            default: begin
               scl_low_ff <= (st_ff != HS_STOP);
            end
         endcase
      end
   end

   // User-side results
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_data_o <= 8'h00;
         rd_valid_o <= 1'h0;
         done_o <= 1'h0;
         nack_o <= 1'h0;
      end else if (ce_i) begin
         rd_valid_o <= 1'h0;
         done_o <= 1'h0;
         nack_o <= 1'h0;
         if (tick && st_ff == HS_BYTE && ph_ff == 2'h3) begin
            if (!tx && bit_ff == 4'h7) begin
               rd_data_o <= sh_ff;
               rd_valid_o <= 1'h1;
            end
            if (tx && bit_ff == SEP_ACK_BIT && !ack_ff) begin
               nack_o <= 1'h1;
            end
         end
         if (tick && st_ff == HS_STOP && ph_ff == 2'h3) begin
            done_o <= 1'h1;
         end
      end
   end

   assign bus.scl_host_o = 1'h0;
   assign bus.scl_host_oe = scl_low_ff;
   assign bus.sda_host_o = 1'h0;
   assign bus.sda_host_oe = sda_low_ff;
endmodule
`default_nettype wire

// File: sep_if.sv
// Two-wire link between host end and device end
`timescale 1ns/10ps
`default_nettype none
interface sep_if;
   logic scl_host_o;   // Host clock output value
   logic scl_host_oe;  // Host pulls clock low
   logic sda_host_o;   // Host data output value
   logic sda_host_oe;  // Host pulls data low
   logic sda_dev_o;    // Device data output value
   logic sda_dev_oe;   // Device pulls data low
   logic scl;          // Resolved clock line
   logic sda;          // Resolved data line

   // ****************************************
   // Open-drain resolution with pull-ups
   // ****************************************
   assign scl = !(scl_host_oe && !scl_host_o);
   assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));

   modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
   modport host (input scl, input sda, output scl_host_o, output scl_host_oe,
                 output sda_host_o, output sda_host_oe);
endinterface
`default_nettype wire

// File: sep_pkg.sv
// Shared constants and types for the serial EEPROM read path
package sep_pkg;
   // ****************************************
   // Addressing
   // ****************************************
   localparam logic [3:0] SEP_DEV_TYPE = 4'hA;  // Array device-type field
   localparam logic SEP_RD_BIT = 1'h1;           // Read/write bit for a read
   localparam logic SEP_WR_BIT = 1'h0;           // Read/write bit for a write
   localparam int SEP_DEPTH = 256;               // Array bytes
   localparam logic [7:0] SEP_ADDR_RST = 8'h00;  // Address counter after reset
   localparam logic [3:0] SEP_ACK_BIT = 4'h8;    // Bit index of the ninth clock
   localparam logic SEP_LINE_IDLE = 1'h1;        // Released line level

   // ****************************************
   // Timing
   // ****************************************
   localparam int SEP_CLK_NS = 100;              // System clock period
   localparam int SEP_SCL_NS = 10000;            // Host serial clock period
   localparam int SEP_Q_RAW = SEP_SCL_NS / (4 * SEP_CLK_NS);
   localparam int SEP_Q_CYC = (SEP_Q_RAW < 1) ? 1 : SEP_Q_RAW;
   localparam logic [7:0] SEP_Q_LAST = 8'(SEP_Q_CYC - 1);

   // ****************************************
   // State types
   // ****************************************
   typedef enum logic [2:0] {
      DS_IDLE, DS_DEVADR, DS_ACKDEV, DS_WORD, DS_ACKWORD, DS_TX, DS_TXACK, DS_WAIT
   } sep_dst_e;
   typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BYTE, HS_STOP} sep_hst_e;
   typedef enum logic [1:0] {SQ_WADR, SQ_WORD, SQ_RADR, SQ_DATA} sep_seq_e;
endpackage

// File: sep_sync.sv
// Two-flop synchroniser with edge detection
`timescale 1ns/10ps
`default_nettype none
module sep_sync import sep_pkg::*; (
   input wire logic clk_i,    // System clock
   input wire logic rst_b_i,  // Async reset, active low
   input wire logic ce_i,     // Clock enable
   input wire logic d_i,      // Asynchronous line
   output logic q_o,          // Synchronised level
   output logic rise_o,       // Rising edge pulse
   output logic fall_o        // Falling edge pulse
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;

   // Sync chain; s1 feeds only s2
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1_ff <= SEP_LINE_IDLE;
         s2_ff <= SEP_LINE_IDLE;
         s3_ff <= SEP_LINE_IDLE;
      end else if (ce_i) begin
         s1_ff <= d_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // Edges from the settled stages
   assign q_o = s2_ff;
   assign rise_o = ce_i && s2_ff && !s3_ff;
   assign fall_o = ce_i && !s2_ff && s3_ff;
endmodule
`default_nettype wire

// File: test_serial_eeprom_read_path.sv
// Self-checking bench for the serial EEPROM read path
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_fail++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module test_serial_eeprom_read_path import sep_pkg::*;;
   int n_fail = 0;
   int checks_done = 0;
   int cyc = 0;
   int nb;
   logic clk, rst_b, req, rand_r, ld_we, ready, rd_valid, done, nack, active, nk;
   logic [2:0] hsel, dsel;
   logic [7:0] word, len, ld_addr, ld_data, rd_data, addr_cnt;

   // ****************************************
   // Link and both ends
   // ****************************************
   sep_if link();
   sep_dev_end i_sep_dev_end (.clk_i(clk), .rst_b_i(rst_b), .ce_i(1'h1), .bus(link),
      .sel_i(dsel), .ld_we_i(ld_we), .ld_addr_i(ld_addr), .ld_data_i(ld_data),
      .addr_cnt_o(addr_cnt), .active_o(active));
   sep_host_end i_sep_host_end (.clk_i(clk), .rst_b_i(rst_b), .ce_i(1'h1), .bus(link),
      .req_i(req), .rand_i(rand_r), .sel_i(hsel), .word_i(word), .len_i(len),
      .ready_o(ready), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .done_o(done),
      .nack_o(nack));
   sep_assertions i_sep_assertions (.clk_i(clk), .rst_b_i(rst_b),
      .scl_host_o(link.scl_host_o), .scl_host_oe(link.scl_host_oe),
      .sda_host_o(link.sda_host_o), .sda_host_oe(link.sda_host_oe),
      .sda_dev_o(link.sda_dev_o), .sda_dev_oe(link.sda_dev_oe),
      .scl(link.scl), .sda(link.sda));

   // Array content pattern
   function automatic logic [7:0] exp_byte(input logic [7:0] a);
      return {a[3:0], a[7:4]} ^ 8'h5A;
   endfunction

   // Verdict and end of run
   task complete_run;
      $display("checks %0d errors %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // One read transfer: request, collect bytes, check counts and counter
   task automatic rd_seq(input logic rnd, input logic [2:0] s, input logic [7:0] w, n, nexp,
      a0, input logic ack_ok);
      int t;
      logic [7:0] a;
      a = a0;
      nb = 0;
      nk = 1'h0;
      t = 0;
      @(posedge clk);
      req <= 1'h1;
      rand_r <= rnd;
      hsel <= s;
      word <= w;
      len <= n;
      @(posedge clk);
      req <= 1'h0;
      @(negedge clk);
      `CHK("host busy", 1'h0, ready)
      do begin
         @(negedge clk);
         t++;
         if (nack === 1'h1) begin
            nk = 1'h1;
         end
         if (rd_valid === 1'h1) begin
            `CHK("read byte", exp_byte(a), rd_data)
            a = a + 8'h01;
            nb++;
         end
      end while (done !== 1'h1 && t < 20000);
      `CHK("transfer done", 1'h1, done)
      `CHK("host ready", 1'h1, ready)
      `CHK("bytes read", nexp, 8'(nb))
      `CHK("address refused", !ack_ok, nk)
      `CHK("address counter", a, addr_cnt)
      `CHK("device idle", 1'h0, active)
   endtask

   // ****************************************
   // Clock, timeout and main sequence
   // ****************************************
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   // Cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         complete_run();
      end
   end

   // Reset, preload, then the read scenarios
   initial begin
      rst_b = 1'h0;
      req = 1'h0;
      rand_r = 1'h0;
      hsel = 3'h5;
      dsel = 3'h5;
      word = 8'h00;
      len = 8'h00;
      ld_we = 1'h0;
      ld_addr = 8'h00;
      ld_data = 8'h00;
      repeat (2) @(posedge clk);
      rst_b <= 1'h1;
      @(negedge clk);
      `CHK("counter after reset", SEP_ADDR_RST, addr_cnt)
      for (int i = 0; i < SEP_DEPTH; i++) begin
         @(posedge clk);
         ld_we <= 1'h1;
         ld_addr <= 8'(i);
         ld_data <= exp_byte(8'(i));
      end
      @(posedge clk);
      ld_we <= 1'h0;
      rd_seq(1'h0, 3'h5, 8'h00, 8'h02, 8'h02, 8'h00, 1'h1);
      rd_seq(1'h1, 3'h5, 8'h10, 8'h03, 8'h03, 8'h10, 1'h1);
      rd_seq(1'h0, 3'h5, 8'h00, 8'h00, 8'h01, 8'h13, 1'h1);
      rd_seq(1'h1, 3'h5, 8'hFE, 8'h04, 8'h04, 8'hFE, 1'h1);
      rd_seq(1'h0, 3'h2, 8'h00, 8'h01, 8'h00, 8'h02, 1'h0);
      rd_seq(1'h0, 3'h5, 8'h00, 8'h01, 8'h01, 8'h02, 1'h1);
      complete_run();
   end
endmodule
`default_nettype wire
